/* core/pid_pkg.sv */
package pid_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_MS = 5;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int PERIOD_MIN_STEPS = 1;
    localparam int PERIOD_MAX_STEPS = 200;
    localparam int STEP_W = 8;
    localparam int TICK_W = 16;

    // ****************************************
    // Sources
    // ****************************************
    localparam int NUM_IO = 4;
    localparam int NUM_SRC = 5;
    localparam logic [2:0] SRC_TIMER = 3'h0;
    localparam logic [2:0] SRC_IO0 = 3'h1;
    localparam logic [2:0] SRC_NONE = 3'h7;

    typedef struct packed {
        logic valid;
        logic [2:0] src;
    } pid_dispatch_t;
endpackage : pid_pkg

/* core/pid_timer.sv */
`timescale 1ns/1ps
module pid_timer (
    input wire logic clock,
    input wire logic srst,
    input wire logic run,
    input wire logic [pid_pkg::STEP_W-1:0] period_steps,
    output logic tick
);
    logic [pid_pkg::TICK_W-1:0] cnt;
    logic [pid_pkg::STEP_W-1:0] steps;
    logic [pid_pkg::TICK_W-1:0] next_cnt;
    logic [pid_pkg::STEP_W-1:0] next_steps;
    logic next_tick;
    logic [pid_pkg::STEP_W-1:0] limit;

    always_comb begin
        // Clamp to the legal 5 ms .. 1000 ms range
        limit = period_steps;
        if (period_steps < pid_pkg::STEP_W'(pid_pkg::PERIOD_MIN_STEPS)) begin
            limit = pid_pkg::STEP_W'(pid_pkg::PERIOD_MIN_STEPS);
        end else if (period_steps > pid_pkg::STEP_W'(pid_pkg::PERIOD_MAX_STEPS)) begin
            limit = pid_pkg::STEP_W'(pid_pkg::PERIOD_MAX_STEPS);
        end
        next_cnt = cnt;
        next_steps = steps;
        next_tick = 1'b0;
        if (!run) begin
            next_cnt = '0;
            next_steps = '0;
        end else if (cnt == pid_pkg::TICK_W'(pid_pkg::TICK_CYCLES - 1)) begin
            next_cnt = '0;
            if (steps + 8'h01 >= limit) begin
                next_steps = '0;
                next_tick = 1'b1;
            end else begin
                next_steps = steps + 8'h01;
            end
        end else begin
            next_cnt = cnt + 16'h0001;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            cnt <= '0;
            steps <= '0;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            steps <= next_steps;
            tick <= next_tick;
        end
    end
endmodule : pid_timer

/* core/pid_dispatcher.sv */
`timescale 1ns/1ps
// How it works
// - The timer request, level 0, is dispatched before any I/O request, level 1.
// - I/O requests rank 0 to 3 for sources one to four, 0 most urgent.
// - Requests during a running handler wait and then go one by one in priority order.
// - The mask command blocks dispatch but keeps requests; the unmask command releases them.
// - Interrupts stay masked through the first scan after entering run and unmask at the second.
// - I/O source 0 is the interrupt module nearest the CPU, higher numbers farther away.
// - The timer request repeats every 5 to 1000 ms in 5 ms steps.
// - An enabled request suspends the scan and starts its handler on the clock after it turns pending.
module pid_dispatcher (
    input wire logic clock,
    input wire logic srst,
    input wire logic run_mode,
    input wire logic scan_end,
    input wire logic global_interrupt_mask_cmd,
    input wire logic global_interrupt_unmask_cmd,
    input wire logic [pid_pkg::STEP_W-1:0] timer_period_steps,
    input wire logic [pid_pkg::NUM_IO-1:0] io_irq,
    input wire logic handler_done,
    output pid_pkg::pid_dispatch_t dispatch,
    output logic handler_active,
    output logic scan_suspend,
    output logic [pid_pkg::NUM_SRC-1:0] pending
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    // Module requests are asynchronous pins; two flops before any use
    logic [pid_pkg::NUM_IO-1:0] io_meta;
    logic [pid_pkg::NUM_IO-1:0] io_sync;
    logic [pid_pkg::NUM_IO-1:0] io_prev;
    logic [pid_pkg::NUM_IO-1:0] next_io_meta;
    logic [pid_pkg::NUM_IO-1:0] next_io_sync;
    logic [pid_pkg::NUM_IO-1:0] next_io_prev;

    always_comb begin
        next_io_meta = io_irq;
        next_io_sync = io_meta;
        next_io_prev = io_sync;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            io_meta <= '0;
            io_sync <= '0;
            io_prev <= '0;
        end else begin
            io_meta <= next_io_meta;
            io_sync <= next_io_sync;
            io_prev <= next_io_prev;
        end
    end

    // ****************************************
    // Timer source
    // ****************************************
    logic timer_tick;

    pid_timer u_timer (
        .clock(clock),
        .srst(srst),
        .run(run_mode),
        .period_steps(timer_period_steps),
        .tick(timer_tick)
    );

    // ****************************************
    // Pending latches and enable state
    // ****************************************
    typedef enum logic [1:0] {PID_HALT, PID_FIRST_SCAN, PID_RUNNING} pid_mode_t;

    pid_mode_t mode;
    pid_mode_t next_mode;
    logic sw_enable;
    logic next_sw_enable;
    logic [pid_pkg::NUM_SRC-1:0] next_pending;
    logic [pid_pkg::NUM_SRC-1:0] raw_req;
    logic [pid_pkg::NUM_SRC-1:0] grant_onehot;
    logic next_handler_active;
    pid_pkg::pid_dispatch_t next_dispatch;
    logic enabled;
    logic [2:0] pick;
    logic found;
    logic next_scan_suspend;
    logic [pid_pkg::NUM_IO-1:0] io_rise;

    // One pulse per rise; a line held high requests only once
    assign io_rise = io_sync & ~io_prev;
    // Timer tick in bit 0, then the rising edge of each module line in physical slot order
    assign raw_req = {io_rise, timer_tick};

    always_comb begin
        next_mode = mode;
        case (mode)
            PID_HALT: begin
                if (run_mode) begin
                    next_mode = PID_FIRST_SCAN;
                end
            end
            PID_FIRST_SCAN: begin
                if (!run_mode) begin
                    next_mode = PID_HALT;
                end else if (scan_end) begin
                    next_mode = PID_RUNNING;
                end
            end
            PID_RUNNING: begin
                if (!run_mode) begin
                    next_mode = PID_HALT;
                end
            end
            default: begin
                next_mode = PID_HALT;
            end
        endcase
    end

    always_comb begin
        next_sw_enable = sw_enable;
        // Program command; unmask wins if both arrive together
        if (global_interrupt_mask_cmd) begin
            next_sw_enable = 1'b0;
        end
        if (global_interrupt_unmask_cmd) begin
            next_sw_enable = 1'b1;
        end
        if (mode == PID_HALT) begin
            next_sw_enable = 1'b1;
        end
    end

    // ****************************************
    // Priority pick
    // ****************************************
    always_comb begin
        found = 1'b0;
        pick = pid_pkg::SRC_NONE;
        // Lowest index wins: timer first, then I/O sources 0..3
        for (int i = 0; i < pid_pkg::NUM_SRC; i++) begin
            if (!found && pending[i]) begin
                found = 1'b1;
                pick = 3'(i);
            end
        end
    end

    // Masking holds requests, it never drops them
    assign enabled = (mode == PID_RUNNING) && sw_enable;

    // ****************************************
    // Dispatch and handler tracking
    // ****************************************
    always_comb begin
        next_dispatch = '{valid: 1'b0, src: pid_pkg::SRC_NONE};
        next_handler_active = handler_active;
        grant_onehot = '0;
        if (handler_active) begin
            // No preemption; new requests just stay pending
            if (handler_done) begin
                next_handler_active = 1'b0;
            end
        end else if (enabled && found) begin
            next_dispatch = '{valid: 1'b1, src: pick};
            next_handler_active = 1'b1;
            grant_onehot[pick] = 1'b1;
        end
        if (mode == PID_HALT) begin
            next_handler_active = 1'b0;
        end
        // Scan resumes in the same cycle the handler ends
        next_scan_suspend = next_handler_active;
    end

    // ****************************************
    // Per-source pending latches
    // ****************************************
    // New arrival beats the dispatch clear of the same source, so none is lost
    for (genvar s = 0; s < pid_pkg::NUM_SRC; s++) begin : g_pend
        assign next_pending[s] = (mode != PID_HALT)
            && (raw_req[s] || (pending[s] && !grant_onehot[s]));
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            mode <= PID_HALT;
        end else begin
            mode <= next_mode;
        end
    end

    // Halt and reset both leave the program mask open
    always_ff @(posedge clock) begin
        if (srst) begin
            sw_enable <= 1'b1;
        end else begin
            sw_enable <= next_sw_enable;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pending <= '0;
        end else begin
            pending <= next_pending;
        end
    end

    // Outputs are flops so the far side never sees a decode glitch
    always_ff @(posedge clock) begin
        if (srst) begin
            handler_active <= 1'b0;
            dispatch <= '{valid: 1'b0, src: pid_pkg::SRC_NONE};
            scan_suspend <= 1'b0;
        end else begin
            handler_active <= next_handler_active;
            dispatch <= next_dispatch;
            scan_suspend <= next_scan_suspend;
        end
    end
endmodule : pid_dispatcher

/* test/pid_chk.sv */
`timescale 1ns/1ps
module pid_chk (
    input wire logic clock,
    input wire logic srst,
    input wire logic run_mode,
    input wire logic scan_end,
    input wire logic global_interrupt_mask_cmd,
    input wire logic global_interrupt_unmask_cmd,
    input wire logic handler_done,
    input wire pid_pkg::pid_dispatch_t dispatch,
    input wire logic handler_active,
    input wire logic scan_suspend,
    input wire logic [pid_pkg::NUM_SRC-1:0] pending
);
    // ****************************************
    // Mode tracking and checks
    // ****************************************
    logic was_run;
    logic first_scan;
    logic masked;
    // Only states that forbid dispatch; exact latency is judged by the bench
    always_ff @(posedge clock) begin
        was_run <= run_mode && !srst;
        first_scan <= !srst && run_mode && (!was_run || (first_scan && !scan_end));
        masked <= !srst && run_mode && !first_scan && !global_interrupt_unmask_cmd
            && (masked || global_interrupt_mask_cmd);
    end
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    AST_SUSP: assert property (scan_suspend == handler_active)
        else $error("suspend differs from handler");
    AST_START: assert property (dispatch.valid |-> handler_active && !$past(handler_active))
        else $error("dispatch while busy");
    AST_ONCE: assert property (dispatch.valid |=> !dispatch.valid)
        else $error("dispatch too long");
    AST_DONE: assert property (handler_done && handler_active |=> !handler_active)
        else $error("handler did not end");
    AST_CLR: assert property (dispatch.valid |->
        ((($past(pending) >> dispatch.src) & 5'h01) == 5'h01) && !pending[dispatch.src])
        else $error("pending flag wrong");
    AST_TIMER: assert property (dispatch.valid && $past(pending[0]) |->
        dispatch.src == pid_pkg::SRC_TIMER)
        else $error("timer not first");
    AST_RANK: assert property (dispatch.valid |->
        ($past(pending) & ((5'h01 << dispatch.src) - 5'h01)) == 5'h00)
        else $error("rank order");
    AST_FIRST: assert property (first_scan && $past(first_scan) |-> !dispatch.valid)
        else $error("dispatch in first scan");
    AST_MASK: assert property (masked && $past(masked) |-> !dispatch.valid)
        else $error("dispatch while masked");
    C_TIMER: cover property (dispatch.valid && dispatch.src == 3'h0);
    C_LAST: cover property (dispatch.valid && dispatch.src == 3'h4);
    C_END: cover property ($fell(handler_active));
endmodule : pid_chk
bind pid_dispatcher pid_chk chk (.clock, .srst, .run_mode, .scan_end,
    .global_interrupt_mask_cmd, .global_interrupt_unmask_cmd, .handler_done,
    .dispatch, .handler_active, .scan_suspend, .pending);

/* test/pid_partner.sv */
`timescale 1ns/1ps
module pid_partner (
    input wire logic clock,
    input wire pid_pkg::pid_dispatch_t dispatch,
    output logic [pid_pkg::NUM_IO-1:0] io_irq,
    output logic handler_done
);
    // ****************************************
    // Request lines and handler
    // ****************************************
    int svc = 4;
    logic [2:0] got[$];
    // Bit 0 is the module nearest the CPU
    task automatic raise(input logic [3:0] m);
        @(posedge clock);
        io_irq <= m;
        repeat (3) @(posedge clock);
        io_irq <= 4'h0;
    endtask : raise
    initial begin
        io_irq = 4'h0;
        handler_done = 1'b0;
        forever begin
            @(posedge clock);
            if (dispatch.valid === 1'b1) begin
                got.push_back(dispatch.src);
                repeat (svc) @(posedge clock);
                handler_done <= 1'b1;
                @(posedge clock);
                handler_done <= 1'b0;
            end
        end
    end
endmodule : pid_partner

/* test/pid_dispatcher_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module pid_dispatcher_tb_top;
    // ****************************************
    // Bench
    // ****************************************
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic run_mode = 1'b0;
    logic scan_end = 1'b0;
    logic mask_cmd = 1'b0;
    logic unmask_cmd = 1'b0;
    logic [3:0] io_irq;
    logic handler_done;
    pid_pkg::pid_dispatch_t dispatch;
    logic handler_active;
    logic [4:0] pending;
    logic scan_suspend;
    logic [7:0] period_steps = 8'h01;
    int errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int t_run = 0;
    always #50 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    pid_dispatcher dut (.clock, .srst, .run_mode, .scan_end, .global_interrupt_mask_cmd(mask_cmd),
        .global_interrupt_unmask_cmd(unmask_cmd), .timer_period_steps(period_steps), .io_irq,
        .handler_done, .dispatch, .handler_active, .scan_suspend, .pending);
    pid_partner partner (.clock, .dispatch, .io_irq, .handler_done);
    task automatic end_of_test;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test
    // Select by code: a ref argument may not take a nonblocking assignment
    task automatic pulse(input int which);
        @(posedge clock);
        if (which == 0) begin
            scan_end <= 1'b1;
        end else if (which == 1) begin
            mask_cmd <= 1'b1;
        end else begin
            unmask_cmd <= 1'b1;
        end
        @(posedge clock);
        scan_end <= 1'b0;
        mask_cmd <= 1'b0;
        unmask_cmd <= 1'b0;
    endtask : pulse
    // Also lets the last handler finish so scenarios never overlap
    task automatic wait_got(input int n, input int lim);
        for (int i = 0; i < lim && partner.got.size() < n; i++) @(posedge clock);
        `CHK(partner.got.size() >= n, 1'b1)
        if (partner.got.size() < n) end_of_test();
        repeat (partner.svc + 4) @(posedge clock);
    endtask : wait_got
    task automatic sc_first_scan;
        @(posedge clock);
        run_mode <= 1'b1;
        t_run = cyc;
        partner.raise(4'h4);
        repeat (10) @(posedge clock);
        `CHK(partner.got.size(), 0)
        `CHK(pending[3], 1'b1)
        pulse(0);
        repeat (3) @(posedge clock);
        `CHK(scan_suspend, 1'b1)
        `CHK(handler_active, 1'b1)
        wait_got(1, 5);
        `CHK(partner.got[0], 3'h3)
        `CHK(scan_suspend, 1'b0)
    endtask : sc_first_scan
    task automatic sc_priority;
        partner.got.delete();
        partner.svc = 12;
        partner.raise(4'hf);
        wait_got(4, 200);
        for (int i = 0; i < 4; i++) `CHK(partner.got[i], 3'(i + 1))
        `CHK(pending, 5'h00)
        partner.got.delete();
        partner.raise(4'h1);
        wait_got(1, 20);
        `CHK(partner.got[0], 3'h1)
    endtask : sc_priority
    task automatic sc_mask;
        partner.got.delete();
        pulse(1);
        partner.raise(4'h2);
        repeat (20) @(posedge clock);
        `CHK(partner.got.size(), 0)
        `CHK(pending[2], 1'b1)
        pulse(2);
        wait_got(1, 10);
        `CHK(partner.got[0], 3'h2)
    endtask : sc_mask
    task automatic sc_timer;
        partner.got.delete();
        pulse(1);
        partner.raise(4'h1);
        for (int i = 0; i < 60000 && pending[0] !== 1'b1; i++) @(posedge clock);
        `CHK((cyc - t_run) inside {[50000:50006]}, 1'b1)
        if (pending[0] !== 1'b1) end_of_test();
        pulse(2);
        wait_got(2, 100);
        `CHK(partner.got[0], 3'h0)
        `CHK(partner.got[1], 3'h1)
    endtask : sc_timer
    // Halt drops pending work and the mask; re-entry masks the first scan again
    task automatic sc_halt;
        partner.got.delete();
        pulse(1);
        partner.raise(4'h8);
        @(posedge clock);
        run_mode <= 1'b0;
        repeat (3) @(posedge clock);
        `CHK(pending, 5'h00)
        `CHK(handler_active, 1'b0)
        run_mode <= 1'b1;
        partner.raise(4'h8);
        repeat (10) @(posedge clock);
        `CHK(partner.got.size(), 0)
        `CHK(pending[4], 1'b1)
        pulse(0);
        wait_got(1, 5);
        `CHK(partner.got[0], 3'h4)
    endtask : sc_halt
    initial begin
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        // Below the legal range, so the clamp must give one 5 ms step
        period_steps <= 8'h00;
        sc_first_scan();
        sc_priority();
        sc_mask();
        sc_timer();
        sc_halt();
        end_of_test();
    end
endmodule : pid_dispatcher_tb_top
